/* src/pipe_status_defines.vh */
// constants for the per-pipe status block of the usb host controller
`ifndef PIPE_STATUS_DEFINES_VH
`define PIPE_STATUS_DEFINES_VH

`define NUM_PIPES        7
`define STATUS_BASE      12'h530
`define CLEAR_BASE       12'h560
`define PIPE_STRIDE      12'h004
`define STATUS_RESET     32'h00000000

`define BIT_IN_STORED    0
`define BIT_OUT_FREE     1
`define BIT_SETUP_LATE   2
`define BIT_FAULT        3
`define BIT_NAK          4
`define BIT_OVERFLOW     5
`define BIT_STALL_CRC    6
`define BIT_SHORT        7
`define POS_TOGGLE       8
`define POS_OCCUPIED     12
`define POS_BANK         14
`define BIT_ACCESS       16

`define TYPE_CONTROL     2'h0
`define TYPE_ISO         2'h1
`define TYPE_BULK        2'h2
`define TYPE_INTERRUPT   2'h3

`define TOKEN_SETUP      2'h0
`define TOKEN_IN         2'h1
`define TOKEN_OUT        2'h2

`define TOGGLE_DATA0     2'h0
`define TOGGLE_DATA1     2'h1

`endif

/* src/bank_tracker.v */
// bank occupancy and bank pointers of one pipe
`timescale 1ns/1ps
module bank_tracker (
	input  wire       pclk,       // bus clock
	input  wire       presetn,    // async reset, low
	input  wire       clear,      // pipe reset, level
	input  wire [1:0] banks_code, // 0..2 = 1..3 banks
	input  wire       fill,       // a bank became busy
	input  wire       drain,      // a busy bank was freed
	output reg  [1:0] occ_q,      // busy bank count
	output reg  [1:0] wr_q,       // bank being filled
	output reg  [1:0] rd_q,       // bank being drained
	output wire       full        // every bank busy
);
	reg  [1:0] occ_d;
	wire       do_fill;
	wire       do_drain;

	function [1:0] step;
		input [1:0] idx;
		input [1:0] last;
		begin
			step = (idx >= last) ? 2'h0 : idx + 2'h1;
		end
	endfunction

	assign full     = (occ_q > banks_code);
	// a fill with no room or a drain with nothing busy is dropped, count wraps only when banks_code is 3
	assign do_fill  = fill & ~full;
	assign do_drain = drain & (occ_q != 2'h0);

	always @* begin
		occ_d = occ_q;
		if (do_fill & ~do_drain) begin
			occ_d = occ_q + 2'h1;
		end else if (do_drain & ~do_fill) begin
			occ_d = occ_q - 2'h1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			occ_q <= 2'h0;
			wr_q  <= 2'h0;
			rd_q  <= 2'h0;
		end else if (clear) begin
			occ_q <= 2'h0;
			wr_q  <= 2'h0;
			rd_q  <= 2'h0;
		end else begin
			occ_q <= occ_d;
			if (do_fill) begin
				wr_q <= step(wr_q, banks_code);
			end
			if (do_drain) begin
				rd_q <= step(rd_q, banks_code);
			end
		end
	end
endmodule // bank_tracker

/* src/usb_host_pipe_status.v */
// per-pipe status, event flags and write-one-to-clear register with apb access
`timescale 1ns/1ps
`include "pipe_status_defines.vh"
module usb_host_pipe_status (
	input  wire        pclk,              // bus clock, 25 MHz
	input  wire        presetn,           // async reset, low
	input  wire        psel,              // apb select
	input  wire        penable,           // apb access phase
	input  wire        pwrite,            // apb write
	input  wire [11:0] paddr,             // apb byte address
	input  wire [31:0] pwdata,            // apb write data
	output reg  [31:0] prdata,            // apb read data
	output wire        pready,            // apb ready
	output wire        pslverr,           // apb error, unmapped or wrong direction
	input  wire [13:0] pipe_type,         // 2 bits per pipe
	input  wire [13:0] pipe_token,        // 2 bits per pipe
	input  wire [13:0] pipe_banks,        // 2 bits per pipe, banks-1
	input  wire [6:0]  pipe_reset,        // clears pipe state, level
	input  wire [6:0]  toggle_reset,      // out toggle to data0
	input  wire [55:0] irq_enable,        // 8 per pipe, flag layout
	input  wire [6:0]  occupied_count_irq_enable, // busy bank irq enable
	input  wire [6:0]  pipe_fault_source, // any error source set
	input  wire [6:0]  usb_bank_done,     // bus side bank done, pulse
	input  wire [6:0]  usb_rx_pid,        // pid of stored in packet
	input  wire [6:0]  user_bank_release, // software side bank done
	input  wire [6:0]  cur_bank_full,     // current bank byte full
	input  wire [6:0]  cur_bank_empty,    // current bank byte empty
	input  wire [6:0]  usb_packet_due,    // transaction slot, pulse
	input  wire [6:0]  ev_short_pkt,      // short packet received
	input  wire [6:0]  ev_stall,          // stall handshake
	input  wire [6:0]  ev_crc_err,        // crc error
	input  wire [6:0]  ev_overflow,       // too much data
	input  wire [6:0]  ev_nak,            // nak handshake
	input  wire [6:0]  ev_pipe_fault,     // pipe error
	output wire [6:0]  per_pipe_interrupt, // registered, level
	output wire [6:0]  freeze_req,        // registered pulse
	output wire [6:0]  send_zlp,          // registered pulse
	output wire [6:0]  drop_packet,       // registered pulse
	output wire [6:0]  ack_dropped,       // registered pulse
	output wire [6:0]  tx_toggle          // pid of next out packet
);
	// address decode: {hit, pipe index}
	function [3:0] decode;
		input [11:0] addr;
		input [11:0] base;
		reg   [11:0] off;
		begin
			off = addr - base;
			if (addr >= base && off < 12'h01C && off[1:0] == 2'h0) begin
				decode = {1'b1, off[4:2]};
			end else begin
				decode = 4'h0;
			end
		end
	endfunction

	wire [3:0]   sta_dec;
	wire [3:0]   clr_dec;
	wire         setup_ph;
	wire         wr_acc;
	wire [118:0] status_flat;
	reg  [31:0]  rd_word;

	assign sta_dec  = decode(paddr, `STATUS_BASE);
	assign clr_dec  = decode(paddr, `CLEAR_BASE);
	assign setup_ph = psel & ~penable;
	assign wr_acc   = psel & penable & pwrite & clr_dec[3];
	// zero wait states: read data is caught in the setup cycle
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~(sta_dec[3] & ~pwrite) & ~(clr_dec[3] & pwrite);

	always @* begin
		rd_word = 32'h00000000;
		if (sta_dec[3] && !pwrite) begin
			rd_word[16:0] = status_flat[sta_dec[2:0]*17 +: 17];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `STATUS_RESET;
		end else if (setup_ph) begin
			prdata <= rd_word; // clear register always reads zero
		end
	end

	genvar i;
	generate
		for (i = 0; i < `NUM_PIPES; i = i + 1) begin : g_pipe
			wire [1:0] ty;
			wire [1:0] tk;
			wire [1:0] nb;
			wire       is_in;
			wire       is_iso;
			wire       is_int;
			wire       periodic;
			wire       fill;
			wire       drain;
			wire [1:0] occ;
			wire [1:0] wr_idx;
			wire [1:0] rd_idx;
			wire       full;
			wire [1:0] cur;
			wire       late;
			wire [7:0] set_v;
			wire [7:0] clr_v;
			wire [7:0] flag_d;
			wire       allowed;
			wire       busy_evt;
			wire [1:0] tog;
			reg  [7:0] flag_q;
			reg        tog_q;
			reg  [2:0] pid_q;
			reg  [1:0] bank_q;
			reg        irq_q;
			reg        freeze_q;
			reg        zlp_q;
			reg        drop_q;
			reg        ack_q;

			assign ty       = pipe_type[2*i +: 2];
			assign tk       = pipe_token[2*i +: 2];
			assign nb       = pipe_banks[2*i +: 2];
			assign is_in    = (tk == `TOKEN_IN);
			assign is_iso   = (ty == `TYPE_ISO);
			assign is_int   = (ty == `TYPE_INTERRUPT);
			assign periodic = is_iso | is_int;

			// software fills out banks and drains in banks; the bus does the opposite
			assign fill  = is_in ? usb_bank_done[i] : user_bank_release[i];
			assign drain = is_in ? user_bank_release[i] : usb_bank_done[i];

			bank_tracker u_banks (
				.pclk       (pclk),
				.presetn    (presetn),
				.clear      (pipe_reset[i]),
				.banks_code (nb),
				.fill       (fill),
				.drain      (drain),
				.occ_q      (occ),
				.wr_q       (wr_idx),
				.rd_q       (rd_idx),
				.full       (full)
			);

			// software-facing bank: the one it writes (out) or reads (in)
			assign cur = is_in ? rd_idx : wr_idx;

			// out: nothing filled in time; in: no free bank for the arriving packet
			assign late = usb_packet_due[i] & periodic &
				(is_in ? full : (occ == 2'h0));

			assign set_v[`BIT_IN_STORED]  = is_in & usb_bank_done[i];
			assign set_v[`BIT_OUT_FREE]   = (tk == `TOKEN_OUT) & usb_bank_done[i];
			assign set_v[`BIT_SETUP_LATE] = ((tk == `TOKEN_SETUP) & usb_bank_done[i]) | late;
			assign set_v[`BIT_FAULT]      = ev_pipe_fault[i];
			assign set_v[`BIT_NAK]        = ev_nak[i];
			assign set_v[`BIT_OVERFLOW]   = ev_overflow[i];
			assign set_v[`BIT_STALL_CRC]  = is_iso ? ev_crc_err[i] : ev_stall[i];
			assign set_v[`BIT_SHORT]      = ev_short_pkt[i];

			// the fault flag has no clear bit; it follows its error sources
			assign clr_v = (wr_acc && clr_dec[2:0] == i) ? (pwdata[7:0] & 8'hF7) : 8'h00;

			// a new event in the clearing cycle wins over the clear
			assign flag_d = set_v | (flag_q & ~clr_v & 8'hF7) |
				({7'h00, flag_q[`BIT_FAULT] & pipe_fault_source[i]} << `BIT_FAULT);

			assign allowed = (is_in ? (occ != 2'h0) & ~cur_bank_empty[i]
				: ~full & ~cur_bank_full[i]) &
				~(flag_q[`BIT_STALL_CRC] & ~is_iso) & ~flag_q[`BIT_FAULT];

			assign busy_evt = occupied_count_irq_enable[i] &
				(is_in ? (occ == 2'h0) : full);

			assign tog = is_in ? {1'b0, pid_q[cur]} : {1'b0, tog_q};

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flag_q   <= 8'h00;
					tog_q    <= 1'b0;
					pid_q    <= 3'h0;
					bank_q   <= 2'h0;
					irq_q    <= 1'b0;
					freeze_q <= 1'b0;
					zlp_q    <= 1'b0;
					drop_q   <= 1'b0;
					ack_q    <= 1'b0;
				end else if (pipe_reset[i]) begin
					flag_q   <= 8'h00;
					bank_q   <= 2'h0;
					irq_q    <= 1'b0;
					freeze_q <= 1'b0;
					zlp_q    <= 1'b0;
					drop_q   <= 1'b0;
					ack_q    <= 1'b0;
				end else begin
					flag_q <= flag_d;
					// registered copy, so it trails access allowed by a cycle
					bank_q <= (ty == `TYPE_CONTROL) ? 2'h0 : cur;
					if (toggle_reset[i]) begin
						tog_q <= 1'b0;
					end else if (!is_in && usb_bank_done[i]) begin
						tog_q <= ~tog_q;
					end
					if (is_in && usb_bank_done[i] && !full) begin
						pid_q[wr_idx] <= usb_rx_pid[i];
					end
					irq_q    <= (|(flag_q & irq_enable[8*i +: 8])) | busy_evt;
					freeze_q <= ev_stall[i] & ~is_iso;
					zlp_q    <= late & ~is_in;
					drop_q   <= late & is_in;
					ack_q    <= late & is_in & is_int;
				end
			end

			assign status_flat[17*i +: 17] = {allowed, bank_q, occ, 2'h0,
				tog, flag_q};
			assign per_pipe_interrupt[i] = irq_q;
			assign freeze_req[i]  = freeze_q;
			assign send_zlp[i]    = zlp_q;
			assign drop_packet[i] = drop_q;
			assign ack_dropped[i] = ack_q;
			assign tx_toggle[i]   = tog_q;
		end
	endgenerate
endmodule // usb_host_pipe_status

/* verif/pipe_status_sva.sv */
// assertions on the ports of the pipe status block
`timescale 1ns/1ps
module pipe_status_sva (
	input wire        pclk,                      // clock
	input wire        presetn,                   // reset, low
	input wire        psel,                      // select
	input wire        penable,                   // access
	input wire        pwrite,                    // write
	input wire [11:0] paddr,                     // address
	input wire [31:0] prdata,                    // read data
	input wire [13:0] pipe_type,                 // types
	input wire [55:0] irq_enable,                // flag enables
	input wire [6:0]  occupied_count_irq_enable, // busy enable
	input wire [6:0]  pipe_reset,                // pipe clear
	input wire [6:0]  ev_nak,                    // nak pulse
	input wire [6:0]  ev_stall,                  // stall pulse
	input wire [6:0]  usb_packet_due,            // slot pulse
	input wire [6:0]  per_pipe_interrupt,        // interrupts
	input wire [6:0]  freeze_req,                // freeze pulse
	input wire [6:0]  send_zlp,                  // zlp pulse
	input wire [6:0]  drop_packet,               // drop pulse
	input wire [6:0]  ack_dropped                // ack pulse
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	nak_irq_a: assert property (ev_nak[0] && irq_enable[4] && !pipe_reset[0] |-> ##2 per_pipe_interrupt[0])
		else $error("nak interrupt missing");
	stall_freeze_a: assert property (ev_stall[0] && pipe_type[1:0] != 2'h1 && !pipe_reset[0] |=> freeze_req[0])
		else $error("stall did not freeze");
	iso_nofreeze_a: assert property (ev_stall[1] && pipe_type[3:2] == 2'h1 |=> !freeze_req[1])
		else $error("iso pipe frozen");
	clr_reads_zero_a: assert property (psel && penable && !pwrite && paddr == 12'h560 |-> prdata == 32'h0)
		else $error("clear register read not zero");
	irq_masked_a: assert property (irq_enable[7:0] == 8'h00 && !occupied_count_irq_enable[0] |=> !per_pipe_interrupt[0])
		else $error("interrupt while disabled");
	drop_ack_a: assert property (drop_packet[2] && pipe_type[5:4] == 2'h3 |-> ack_dropped[2])
		else $error("dropped packet not acked");
	drop_cause_a: assert property (drop_packet[2] |-> $past(usb_packet_due[2]))
		else $error("drop without packet");
	zlp_cause_a: assert property (send_zlp[4] |-> $past(usb_packet_due[4]))
		else $error("zlp without slot");
endmodule // pipe_status_sva

/* verif/usb_device_model.sv */
// behavioural usb device driving one-cycle bus events into the block
`timescale 1ns/1ps
module usb_device_model (
	input  wire       pclk,               // clock
	output wire [6:0] usb_bank_done,      // bank sent or stored
	output wire [6:0] usb_packet_due,     // transaction slot
	output wire [6:0] ev_short_pkt,       // short packet
	output wire [6:0] ev_stall,           // stall handshake
	output wire [6:0] ev_overflow,        // too much data
	output wire [6:0] ev_nak,             // nak handshake
	output wire [6:0] ev_pipe_fault,      // pipe error
	output wire [6:0] ev_crc_err,         // iso crc error
	output reg  [6:0] usb_rx_pid = 7'h00  // pid of stored packet
);
	reg [55:0] ev_q = 56'h0;
	assign {ev_crc_err, ev_pipe_fault, ev_nak, ev_overflow, ev_stall, ev_short_pkt, usb_packet_due, usb_bank_done} = ev_q;
	// pid only counts beside the bank pulse, so it is inverted afterwards
	task pulse(input integer k, input integer p, input pid);
		begin
			@(posedge pclk);
			ev_q[7 * k + p] <= 1'b1;
			usb_rx_pid[p] <= pid;
			@(posedge pclk);
			ev_q[7 * k + p] <= 1'b0;
			usb_rx_pid[p] <= ~pid;
		end
	endtask
endmodule // usb_device_model

/* verif/tb_top.sv */
// testbench for the pipe status block
`timescale 1ns/1ps
module tb_top;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	reg  [13:0] pipe_type = 14'h2936;
	reg  [13:0] pipe_token = 14'h1616;
	reg  [13:0] pipe_banks = 14'h0001;
	reg  [6:0]  pipe_reset = 7'h00;
	reg  [6:0]  toggle_reset = 7'h00;
	reg  [55:0] irq_enable = 56'h0;
	reg  [6:0]  occupied_count_irq_enable = 7'h00;
	reg  [6:0]  pipe_fault_source = 7'h00;
	reg  [6:0]  user_bank_release = 7'h00;
	reg  [6:0]  cur_bank_full = 7'h00;
	reg  [6:0]  cur_bank_empty = 7'h7F;
	wire [6:0]  usb_bank_done, usb_rx_pid, usb_packet_due, ev_short_pkt, ev_stall, ev_crc_err, ev_overflow, ev_nak;
	wire [6:0]  ev_pipe_fault, per_pipe_interrupt, freeze_req, send_zlp, drop_packet, ack_dropped, tx_toggle;
	reg  [1:0]  seen_q = 2'h0;
	reg  [31:0] q;
	reg         err;
	integer     i, k;
	integer     n_mismatch = 0;
	integer     n_compared = 0;
	usb_host_pipe_status dut (.*);
	usb_device_model dev (.*);
	always #20 pclk = ~pclk;
	always @(posedge pclk) seen_q <= seen_q | {send_zlp[4], drop_packet[2]};
	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: got %h want %h", $time, seen, exp);
			end
		end
	endtask
	task apb(input wr, input [11:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			q = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rel(input integer p);
		begin
			@(posedge pclk);
			user_bank_release[p] <= 1'b1;
			@(posedge pclk);
			user_bank_release[p] <= 1'b0;
		end
	endtask
	task final_report;
		begin
			$display("compared %0d mismatched %0d", n_compared, n_mismatch);
			if (n_mismatch == 0 && n_compared > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		#100000;
		n_mismatch = n_mismatch + 1;
		final_report;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 7; i = i + 1) begin
			apb(1'b0, 12'h530 + 12'(4 * i), 32'h0);
			check(q & 32'hFFFEFFFF, 32'h0);
		end
		irq_enable <= 56'hFF;
		// flags 7..4 on a bulk out pipe; zero writes must leave them alone
		for (k = 2; k < 6; k = k + 1) begin
			dev.pulse(k, 0, 1'b0);
			repeat (3) @(posedge pclk);
			check({31'h0, per_pipe_interrupt[0]}, 32'h1);
			apb(1'b0, 12'h530, 32'h0);
			check(q & 32'h000100FF, (32'h1 << (9 - k)) | (k == 3 ? 32'h0 : 32'h10000));
			apb(1'b1, 12'h560, 32'h0);
			apb(1'b0, 12'h530, 32'h0);
			check(q & 32'hFF, 32'h1 << (9 - k));
			apb(1'b1, 12'h560, 32'hF7);
			apb(1'b0, 12'h530, 32'h0);
			check(q & 32'hFF, 32'h0);
		end
		pipe_fault_source <= 7'h01;
		dev.pulse(6, 0, 1'b0);
		apb(1'b1, 12'h560, 32'hFF);
		apb(1'b0, 12'h530, 32'h0);
		check(q & 32'h000100FF, 32'h8);
		pipe_fault_source <= 7'h00;
		apb(1'b0, 12'h530, 32'h0);
		check(q & 32'hFF, 32'h0);
		dev.pulse(7, 1, 1'b0);
		apb(1'b0, 12'h534, 32'h0);
		check(q & 32'hFF, 32'h40);
		dev.pulse(3, 1, 1'b0);
		irq_enable <= 56'h0;
		occupied_count_irq_enable <= 7'h01;
		rel(0);
		apb(1'b0, 12'h530, 32'h0);
		check(q & 32'h0000F000, 32'h5000);
		rel(0);
		repeat (2) @(posedge pclk);
		check({31'h0, per_pipe_interrupt[0]}, 32'h1);
		apb(1'b0, 12'h530, 32'h0);
		check(q & 32'h0000F000, 32'h2000);
		dev.pulse(0, 0, 1'b0);
		apb(1'b0, 12'h530, 32'h0);
		check(q & 32'h000033FF, 32'h1102);
		check({31'h0, tx_toggle[0]}, 32'h1);
		dev.pulse(0, 2, 1'b1);
		apb(1'b0, 12'h538, 32'h0);
		check(q & 32'h0000F3FF, 32'h1101);
		dev.pulse(1, 2, 1'b0);
		dev.pulse(1, 4, 1'b0);
		apb(1'b0, 12'h538, 32'h0);
		check(q & 32'h4, 32'h4);
		apb(1'b0, 12'h540, 32'h0);
		check(q & 32'h4, 32'h4);
		check({30'h0, seen_q}, 32'h3);
		apb(1'b0, 12'h544, 32'h0);
		check(q & 32'h10000, 32'h0);
		cur_bank_empty <= 7'h5F;
		cur_bank_full <= 7'h01;
		// an in bank can only be read once a packet has been stored in it
		dev.pulse(0, 5, 1'b0);
		apb(1'b0, 12'h544, 32'h0);
		check(q & 32'h10000, 32'h10000);
		apb(1'b0, 12'h530, 32'h0);
		check(q & 32'h10000, 32'h0);
		apb(1'b0, 12'h560, 32'h0);
		check(q, 32'h0);
		apb(1'b0, 12'h600, 32'h0);
		check({31'h0, err}, 32'h1);
		final_report;
	end
endmodule // tb_top
bind usb_host_pipe_status pipe_status_sva chk (.*);
